// ---- rtl/branch_bit_defs.svh ----
// Purpose: offsets, encodings, field positions and reset values for the branch and bit execution block
// Assumes: 16-bit instruction words, 8-bit data, byte-addressed program counter
// Notes: included by bare name; definitions only
`ifndef BRANCH_BIT_DEFS_SVH
`define BRANCH_BIT_DEFS_SVH

`define PC_W 21
`define RF_AW 12
`define PC_RST 21'h000000
`define PC_STEP 21'h000002

`define OPC_JUMP_IF_NONNEGATIVE 8'he7
`define OPC_JUMP_IF_NO_OVERFLOW 8'he5
`define OPC_JUMP_IF_NONZERO 8'he1
`define OPC_JUMP_IF_NO_CARRY 8'he3
`define OPC_UNCONDITIONAL_JUMP 5'h1a
`define OPC_SET_REGISTER_BIT 4'h8
`define OPC_TEST_BIT_SKIP_WHEN_CLEAR 4'hb
`define OPC_TWO_WORD_MOVE 4'hc
`define OPC_TWO_WORD_PREFIX 6'h3b

// Field positions of the 16-bit word
`define F_OPC8_HI 15
`define F_OPC8_LO 8
`define F_OPC5_LO 11
`define F_NIB_LO 12
`define F_OPC6_LO 10
`define F_BIT_HI 11
`define F_BIT_LO 9
`define F_ACCESS 8
`define F_ADDR_HI 7
`define F_OFS11_HI 10

// Access Bank split: low half maps to bank 0, high half to the top bank
`define ACCESS_SPLIT 8'h80
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hf

`endif

// ---- rtl/branch_bit_pkg.sv ----
// Purpose: shared types of the branch and bit execution block
// Assumes: constants live in branch_bit_defs.svh
// Notes: types only
package branch_bit_pkg;

   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b10,
      Q4 = 2'b11
   } q_phase_t;

   typedef enum logic [2:0] {
      K_NOP = 3'b000,
      K_COND_JUMP = 3'b001,
      K_UNCOND_JUMP = 3'b010,
      K_SET_BIT = 3'b011,
      K_TEST_SKIP_CLEAR = 3'b100,
      K_OTHER = 3'b101
   } exec_kind_t;

   typedef struct packed {
      logic negative;
      logic overflow;
      logic zero;
      logic carry;
   } status_flags_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
      logic [7:0] data;
   } host_req_t;

endpackage

// ---- rtl/register_file_ram.sv ----
// Purpose: data register file, one port, registered read data
// Assumes: one access per clock
// Notes: contents have no reset, as in a real data memory
`timescale 1ns/1ps
`include "branch_bit_defs.svh"
module register_file_ram (
   input wire logic clk,
   input wire logic [`RF_AW-1:0] addr,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_reg
);
   logic [7:0] mem [0:(1<<`RF_AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_reg <= mem[addr];
   end
endmodule

// ---- rtl/branch_and_bit_instr_exec.sv ----
// Purpose: execute relative jumps, bit set and bit test with skip over four quarter phases
// Assumes: program memory answers prog_word for prog_addr within the same instruction cycle
// Notes: instructions outside this group run as one-cycle no-operations here
`timescale 1ns/1ps
`include "branch_bit_defs.svh"
module branch_and_bit_instr_exec (
   input wire logic clk,
   input wire logic rst_n,
   output logic [`PC_W-1:0] prog_addr,
   input wire logic [15:0] prog_word,
   input wire branch_bit_pkg::status_flags_t flags,
   input wire logic [3:0] bank_selector,
   input wire branch_bit_pkg::host_req_t host_req,
   output logic host_ack,
   output logic [7:0] host_rdata,
   output branch_bit_pkg::q_phase_t q_phase,
   output branch_bit_pkg::exec_kind_t exec_kind,
   output logic nop_cycle,
   output logic pc_write,
   output logic rf_write
);
   import branch_bit_pkg::*;

   q_phase_t q_reg;
   q_phase_t q_next;
   logic [`PC_W-1:0] pc_reg;
   logic [15:0] instr_reg;
   logic live_reg;
   logic [1:0] flush_reg;
   exec_kind_t kind_reg;
   logic [`PC_W-1:0] offset_reg;
   logic [`PC_W-1:0] target_reg;
   logic taken_reg;
   logic skip_reg;
   logic [7:0] mod_reg;
   logic [2:0] bit_idx;
   logic [7:0] reg_addr;
   logic [`RF_AW-1:0] eff_addr;
   logic [`RF_AW-1:0] ram_addr;
   logic ram_we;
   logic [7:0] ram_wdata;
   logic [7:0] ram_rdata;
   logic cond_met;
   logic fetched_two_word;
   logic host_slot;
   logic [`PC_W-1:0] pc_next;
   logic take_now;
   logic [3:0] access_bank;
   logic [7:0] bit_mask;
   logic bit_clear;

   function automatic exec_kind_t decode(input logic [15:0] w);
      exec_kind_t k;
      // Skip-when-set and every word outside this group run as a one-cycle no-operation
      k = K_OTHER;
      case (w[`F_OPC8_HI:`F_OPC8_LO])
         `OPC_JUMP_IF_NONNEGATIVE: k = K_COND_JUMP;
         `OPC_JUMP_IF_NO_OVERFLOW: k = K_COND_JUMP;
         `OPC_JUMP_IF_NONZERO: k = K_COND_JUMP;
         `OPC_JUMP_IF_NO_CARRY: k = K_COND_JUMP;
         default: begin
            if (w[`F_OPC8_HI:`F_OPC5_LO] == `OPC_UNCONDITIONAL_JUMP) begin
               k = K_UNCOND_JUMP;
            end else if (w[`F_OPC8_HI:`F_NIB_LO] == `OPC_SET_REGISTER_BIT) begin
               k = K_SET_BIT;
            end else if (w[`F_OPC8_HI:`F_NIB_LO] == `OPC_TEST_BIT_SKIP_WHEN_CLEAR) begin
               k = K_TEST_SKIP_CLEAR;
            end
         end
      endcase
      return k;
   endfunction

   // Quarter phase sequencer; every instruction cycle is four clocks
   always_comb begin
      case (q_reg)
         Q1: q_next = Q2;
         Q2: q_next = Q3;
         Q3: q_next = Q4;
         Q4: q_next = Q1;
         default: q_next = Q1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= Q1;
      end else begin
         q_reg <= q_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kind_reg <= K_NOP;
      end else if (q_reg == Q1) begin
         kind_reg <= live_reg ? decode(instr_reg) : K_NOP;
      end
   end

   // double the signed offset in Q2
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         offset_reg <= '0;
      end else if (q_reg == Q2) begin
         if (kind_reg == K_UNCOND_JUMP) begin
            offset_reg <= {{(`PC_W-12){instr_reg[`F_OFS11_HI]}}, instr_reg[`F_OFS11_HI:0], 1'b0};
         end else begin
            offset_reg <= {{(`PC_W-9){instr_reg[`F_ADDR_HI]}}, instr_reg[`F_ADDR_HI:0], 1'b0};
         end
      end
   end

   // Branch condition, each tests its flag for zero
   always_comb begin
      case (instr_reg[`F_OPC8_HI:`F_OPC8_LO])
         `OPC_JUMP_IF_NONNEGATIVE: cond_met = ~flags.negative;
         `OPC_JUMP_IF_NO_OVERFLOW: cond_met = ~flags.overflow;
         `OPC_JUMP_IF_NONZERO: cond_met = ~flags.zero;
         `OPC_JUMP_IF_NO_CARRY: cond_met = ~flags.carry;
         default: cond_met = 1'b0;
      endcase
   end

   assign take_now = (kind_reg == K_UNCOND_JUMP) || ((kind_reg == K_COND_JUMP) && cond_met);

   // target from incremented pc, formed in Q3
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         target_reg <= `PC_RST;
      end else if (q_reg == Q3) begin
         target_reg <= pc_reg + offset_reg;
      end
   end

   // process data in Q3; the decision lives until the next decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         taken_reg <= 1'b0;
      end else if (q_reg == Q3) begin
         taken_reg <= take_now;
      end else if (q_reg == Q1) begin
         taken_reg <= 1'b0;
      end
   end

   // Register file addressing
   assign bit_idx = instr_reg[`F_BIT_HI:`F_BIT_LO];
   assign reg_addr = instr_reg[`F_ADDR_HI:0];

   // One decoder slice per data bit; set and test share the mask
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
         assign bit_mask[gi] = (bit_idx == 3'(gi));
      end
   endgenerate
   assign bit_clear = ~|(ram_rdata & bit_mask);

   // Access Bank: low half of the page in bank 0, high half in the top bank
   always_comb begin
      if (reg_addr < `ACCESS_SPLIT) begin
         access_bank = `ACCESS_LOW_BANK;
      end else begin
         access_bank = `ACCESS_HIGH_BANK;
      end
   end

   assign eff_addr = instr_reg[`F_ACCESS] ? {bank_selector, reg_addr} : {access_bank, reg_addr};

   // Host may only use the port in Q1, which the core never touches
   assign host_slot = (q_reg == Q1);
   assign host_ack = host_req.valid && host_slot;

   always_comb begin
      ram_addr = eff_addr;
      ram_we = 1'b0;
      ram_wdata = mod_reg;
      if (host_slot) begin
         ram_addr = host_req.addr;
         ram_we = host_req.valid && host_req.write;
         ram_wdata = host_req.data;
      end else if (q_reg == Q4 && kind_reg == K_SET_BIT) begin
         ram_we = 1'b1;
      end
   end

   assign rf_write = ram_we && !host_slot;

   register_file_ram u_rf (
      .clk(clk),
      .addr(ram_addr),
      .we(ram_we),
      .wdata(ram_wdata),
      .rdata_reg(ram_rdata)
   );

   // Host read data is loaded at the edge ending Q2 of every instruction cycle and held until the next Q2
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata <= 8'h00;
      end else if (q_reg == Q2) begin
         host_rdata <= ram_rdata;
      end
   end

   // force bit to one in Q3; the other seven bits go back as read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_reg <= 8'h00;
      end else if (q_reg == Q3) begin
         mod_reg <= ram_rdata | bit_mask;
      end
   end

   // skip on clear bit, decided in Q3 and dropped at the next decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_reg <= 1'b0;
      end else if (q_reg == Q3) begin
         skip_reg <= (kind_reg == K_TEST_SKIP_CLEAR) && bit_clear;
      end else if (q_reg == Q1) begin
         skip_reg <= 1'b0;
      end
   end

   // Words needing a second program word
   // These patterns must follow the instruction set, or a skipped second word runs as code
   assign fetched_two_word = (prog_word[`F_OPC8_HI:`F_NIB_LO] == `OPC_TWO_WORD_MOVE) ||
                             (prog_word[`F_OPC8_HI:`F_OPC6_LO] == `OPC_TWO_WORD_PREFIX);

   always_comb begin
      if (taken_reg) begin
         pc_next = target_reg;
      end else begin
         // pc steps by two per fetch
         pc_next = pc_reg + `PC_STEP;
      end
   end

   // One program counter update per instruction cycle, at the edge ending Q4
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= `PC_RST;
      end else if (q_reg == Q4) begin
         pc_reg <= pc_next;
      end
   end

   // Prefetch: the word at prog_addr is taken at the edge ending Q4
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_reg <= 16'h0000;
      end else if (q_reg == Q4) begin
         instr_reg <= prog_word;
      end
   end

   // Discard control; reset starts with one empty cycle since nothing is prefetched yet
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live_reg <= 1'b0;
         flush_reg <= 2'b00;
      end else if (q_reg == Q4) begin
         if (taken_reg) begin
            // A jump and a skip never share a cycle, so the order of these tests is free
            // discard prefetched word
            live_reg <= 1'b0;
            flush_reg <= 2'b00;
         end else if (skip_reg) begin
            live_reg <= 1'b0;
            flush_reg <= fetched_two_word ? 2'b01 : 2'b00;
         end else if (flush_reg != 2'b00) begin
            live_reg <= 1'b0;
            flush_reg <= flush_reg - 2'b01;
         end else begin
            live_reg <= 1'b1;
         end
      end
   end

   assign prog_addr = pc_reg;
   assign q_phase = q_reg;
   assign exec_kind = kind_reg;
   assign nop_cycle = ~live_reg;
   assign pc_write = (q_reg == Q4) && taken_reg;

endmodule

// ---- bench/branch_and_bit_instr_exec_props.sv ----
// Purpose: port timing checks for the branch and bit execution block
// Assumes: one clock, asynchronous active-low reset
// Notes: jump targets are not visible here, so the bench checks them
`timescale 1ns/1ps
`include "branch_bit_defs.svh"
module branch_and_bit_instr_exec_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`PC_W-1:0] prog_addr,
   input wire branch_bit_pkg::q_phase_t q_phase,
   input wire branch_bit_pkg::exec_kind_t exec_kind,
   input wire logic nop_cycle,
   input wire logic pc_write,
   input wire logic rf_write
);
   import branch_bit_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_quarters; q_phase == Q2 ##1 q_phase == Q3 ##1 q_phase == Q4 ##1 q_phase == Q1; endsequence
   sequence s_flush; nop_cycle [*4] ##1 !nop_cycle; endsequence
   property p_phase; q_phase == Q1 |=> s_quarters; endproperty
   a_phase: assert property (p_phase) else $error("phase order");
   property p_pc_q4; pc_write |-> q_phase == Q4 && exec_kind inside {K_COND_JUMP, K_UNCOND_JUMP}; endproperty
   a_pc_q4: assert property (p_pc_q4) else $error("pc write misplaced");
   property p_taken; pc_write |=> s_flush; endproperty
   a_taken: assert property (p_taken) else $error("taken jump length");
   property p_step; q_phase == Q4 && !pc_write |=> prog_addr == $past(prog_addr) + `PC_STEP; endproperty
   a_step: assert property (p_step) else $error("pc step");
   property p_untaken; q_phase == Q4 && exec_kind == K_COND_JUMP && !pc_write |=> !nop_cycle; endproperty
   a_untaken: assert property (p_untaken) else $error("untaken jump flushed");
   property p_bra; q_phase == Q4 && exec_kind == K_UNCOND_JUMP && !nop_cycle |-> pc_write; endproperty
   a_bra: assert property (p_bra) else $error("jump not taken");
   property p_rf; rf_write |-> q_phase == Q4 && exec_kind == K_SET_BIT && !nop_cycle; endproperty
   a_rf: assert property (p_rf) else $error("stray register write");
   property p_set; q_phase == Q2 && exec_kind == K_SET_BIT && !nop_cycle |-> ##2 rf_write ##1 !nop_cycle [*4]; endproperty
   a_set: assert property (p_set) else $error("bit set timing");
endmodule
bind branch_and_bit_instr_exec branch_and_bit_instr_exec_props props_i (.clk(clk), .rst_n(rst_n),
   .prog_addr(prog_addr), .q_phase(q_phase), .exec_kind(exec_kind), .nop_cycle(nop_cycle),
   .pc_write(pc_write), .rf_write(rf_write));

// ---- bench/prog_mem_model.sv ----
// Purpose: program memory on the fetch port
// Assumes: byte address, word aligned
// Notes: answers within the cycle; the bench loads it
`timescale 1ns/1ps
`include "branch_bit_defs.svh"
module prog_mem_model (
   input wire logic [`PC_W-1:0] prog_addr,
   output logic [15:0] prog_word
);
   logic [15:0] rom [2048];
   assign prog_word = rom[prog_addr[11:1]];
endmodule

// ---- bench/branch_and_bit_instr_exec_bench.sv ----
// Purpose: directed run of the branch and bit execution block
// Assumes: registers preloaded through the host port
// Notes: a self-loop at address 0 parks the core until the program is armed
`timescale 1ns/1ps
`include "branch_bit_defs.svh"
module branch_and_bit_instr_exec_bench;
   import branch_bit_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [`PC_W-1:0] prog_addr;
   logic [15:0] prog_word;
   status_flags_t flags = '0;
   logic [3:0] bank_selector = 4'h2;
   host_req_t host_req = '0;
   logic host_ack;
   logic [7:0] host_rdata;
   q_phase_t q_phase;
   exec_kind_t exec_kind;
   logic nop_cycle;
   logic pc_write;
   logic rf_write;
   logic [7:0] rd;
   int err_total = 0;
   int num_checks = 0;
   // Byte address and instruction word
   logic [27:0] prog_tab [19] = '{28'h000d7ff, 28'h002e510, 28'h024e17f, 28'h124e380, 28'h026d3ff,
      28'h826d400, 28'h028e105, 28'h02ae305, 28'h02ce505, 28'h02ee702, 28'h0348e05, 28'h0368134,
      28'h038b090, 28'h03ab290, 28'h03c8005, 28'h03eb290, 28'h040c000, 28'h0428005, 28'h044e700};
   // Flags, nop and kind, byte address for each instruction cycle
   logic [19:0] st [26] = '{20'h81002, 20'h01004, 20'h08024, 20'h01026, 20'h08124, 20'h01126, 20'h08026,
      20'hf2028, 20'hf8826, 20'hf2828, 20'hf8028, 20'h2102a, 20'h1102c, 20'h4102e, 20'h71030, 20'h78034,
      20'h03036, 20'h03038, 20'h0403a, 20'h0403c, 20'h0803e, 20'h04040, 20'h08042, 20'h08044, 20'h81046,
      20'h05048};
   // Address, preload, expected final value
   logic [27:0] reg_tab [4] = '{28'h0050a8a, 28'h2340001, 28'h2050000, 28'hf900101};

   always #25 clk = ~clk;

   branch_and_bit_instr_exec dut (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_word(prog_word),
      .flags(flags), .bank_selector(bank_selector), .host_req(host_req), .host_ack(host_ack),
      .host_rdata(host_rdata), .q_phase(q_phase), .exec_kind(exec_kind), .nop_cycle(nop_cycle),
      .pc_write(pc_write), .rf_write(rf_write));
   prog_mem_model pmem (.prog_addr(prog_addr), .prog_word(prog_word));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic host(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
      int n = 0;
      @(posedge clk) host_req <= '{1'b1, wr, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (host_ack !== 1'b1 && n < 8);
      host_req.valid <= 1'b0;
      check(n < 8, 1'b1);
      @(posedge clk);
      @(negedge clk) q = host_rdata;
   endtask

   // Flags change after decode so they are settled well before the Q3 sample
   task automatic step(input logic [3:0] f, input logic [`PC_W-1:0] pc, input logic nop, input exec_kind_t k);
      @(negedge clk);
      while (q_phase !== Q1) @(negedge clk);
      check(prog_addr, pc);
      check(nop_cycle, nop);
      @(posedge clk) flags <= f;
      @(negedge clk) check(exec_kind, k);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      foreach (pmem.rom[i]) pmem.rom[i] = 16'h0000;
      foreach (prog_tab[i]) pmem.rom[prog_tab[i][27:17]] = prog_tab[i][15:0];
      rst_n <= 1'b1;
      @(negedge clk);
      check(q_phase, Q1);
      check(prog_addr, 0);
      check(nop_cycle, 1'b1);
      foreach (reg_tab[i]) host(1'b1, reg_tab[i][27:16], reg_tab[i][15:8], rd);
      while (!(q_phase === Q1 && nop_cycle === 1'b1 && prog_addr === '0)) @(negedge clk);
      pmem.rom[0] = 16'he705;
      foreach (st[i]) step(st[i][19:16], st[i][11:0], st[i][15], exec_kind_t'(st[i][14:12]));
      foreach (reg_tab[i]) begin
         host(1'b0, reg_tab[i][27:16], 8'h00, rd);
         check(rd, reg_tab[i][7:0]);
      end
      test_done();
   end

   // The run needs under 200 cycles; fifteen times that means a hang
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule
